// file: par_consts.svh
// Register offsets, field positions and reset values of the PHY register bank
`ifndef PAR_CONSTS_SVH
`define PAR_CONSTS_SVH

`define PAR_OFS_REVISION 8'h5e
`define PAR_OFS_CONTROL 8'h62
`define PAR_OFS_STATUS 8'h64
`define PAR_OFS_ADVERT 8'h66
`define PAR_OFS_PARTNER 8'h68

`define PAR_CTRL_RESET 15
`define PAR_CTRL_SPEED 13
`define PAR_CTRL_ANEN 12
`define PAR_CTRL_RESTART 9
`define PAR_CTRL_DUPLEX 8

`define PAR_STS_COMPLETE 5
`define PAR_STS_RFAULT 4
`define PAR_STS_NOFAIL 3
`define PAR_STS_LINK 2
`define PAR_STS_JABBER 1
`define PAR_STS_FIXED 16'h7801

`define PAR_ADV_NP 15
`define PAR_ADV_ACK 14
`define PAR_ADV_PAUSE 10
`define PAR_ADV_T4 9
`define PAR_ADV_FAST_FD 8
`define PAR_ADV_FAST 7
`define PAR_ADV_SLOW_FD 6
`define PAR_ADV_SLOW 5
`define PAR_ADV_WR_MASK 16'h21ff
`define PAR_ADV_RESET 16'h01e1
`define PAR_ADV_VIEW_RESET 16'h05e1
`define PAR_PARTNER_RESET 16'h0000

`endif

// file: par_pkg.sv
// Types shared by the PHY register bank modules
package par_pkg;
    typedef logic [15:0] par_word_t;
    typedef enum logic [1:0] {nway_off, nway_listen, nway_ack, nway_done} par_nway_state_e;
endpackage

// file: par_nway_if.sv
// Carrier between the register bank and the negotiation sequencer
`timescale 1ns/1ps
interface par_nway_if;
    logic enable;
    logic restart;
    logic soft_rst;
    par_pkg::par_word_t advert;
    logic partner_valid;
    logic link_ok;
    logic restart_taken;
    logic complete;
    logic ack;
    logic page_rx;
    logic speed_100;
    logic full_duplex;
    par_pkg::par_word_t rx_word;
    modport seq (
        input enable, restart, soft_rst, advert, partner_valid, link_ok, rx_word,
        output restart_taken, complete, ack, page_rx, speed_100, full_duplex
    );
    modport bank (
        output enable, restart, soft_rst, advert, partner_valid, link_ok, rx_word,
        input restart_taken, complete, ack, page_rx, speed_100, full_duplex
    );
endinterface

// file: par_nway_sequencer.sv
// Auto-negotiation sequencer: partner word exchange and ability resolution
`timescale 1ns/1ps
`include "par_consts.svh"
module par_nway_sequencer (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Register bank side
    par_nway_if.seq nw
);
    par_pkg::par_nway_state_e state;
    par_pkg::par_nway_state_e next_state;
    par_pkg::par_word_t partner;
    logic [1:0] best;

    // Highest common ability: speed then duplex
    function automatic logic [1:0] resolve(input par_pkg::par_word_t a, input par_pkg::par_word_t b);
        logic [15:0] c;
        c = a & b;
        if (c[`PAR_ADV_FAST_FD])
            resolve = 2'h3;
        else if (c[`PAR_ADV_FAST])
            resolve = 2'h2;
        else if (c[`PAR_ADV_SLOW_FD])
            resolve = 2'h1;
        else
            resolve = 2'h0;
    endfunction

    always_comb
    begin
        next_state = state;
        unique case (state)
            par_pkg::nway_off: if (nw.enable) next_state = par_pkg::nway_listen;
            par_pkg::nway_listen: if (nw.partner_valid) next_state = par_pkg::nway_ack;
            par_pkg::nway_ack: if (nw.link_ok) next_state = par_pkg::nway_done;
            par_pkg::nway_done: if (!nw.link_ok) next_state = par_pkg::nway_listen;
        endcase
        if (!nw.enable)
            next_state = par_pkg::nway_off;
        else if (nw.restart || nw.soft_rst)
            next_state = par_pkg::nway_listen;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            state <= par_pkg::nway_off;
        else
            state <= next_state;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            partner <= `PAR_PARTNER_RESET;
        else if (nw.soft_rst)
            partner <= `PAR_PARTNER_RESET;
        else if (nw.partner_valid && state == par_pkg::nway_listen)
            partner <= nw.rx_word;
    end

    assign nw.restart_taken = nw.restart;
    assign nw.complete = (state == par_pkg::nway_done);
    assign nw.ack = (state == par_pkg::nway_ack) || (state == par_pkg::nway_done);
    assign nw.page_rx = nw.partner_valid && nw.enable;
    // Local advertisement against the captured partner word
    assign best = resolve(nw.advert, partner);
    assign nw.speed_100 = best[1];
    assign nw.full_duplex = best[0];
endmodule

// file: par_status_flags.sv
// Latched status flags: remote fault and past link failure
`timescale 1ns/1ps
module par_status_flags (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Events and clears
    input wire logic soft_rst_i,
    input wire logic status_read_i,
    input wire logic remote_fault_i,
    input wire logic link_ok_i,
    // Flags
    output logic remote_fault_o,
    output logic no_fail_o
);
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            remote_fault_o <= 1'b0;
        else if (remote_fault_i)
            remote_fault_o <= 1'b1;
        else if (status_read_i || soft_rst_i)
            remote_fault_o <= 1'b0;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            no_fail_o <= 1'b1;
        else if (!link_ok_i)
            no_fail_o <= 1'b0;
        else if (soft_rst_i)
            no_fail_o <= 1'b1;
    end
endmodule

// file: par_register_bank.sv
// PHY control, status, advertisement and partner ability register bank
`timescale 1ns/1ps
`include "par_consts.svh"
// Functional notes
// - Control bit 15 write restores all PHY registers to defaults; bit reads zero.
// - Control bit 13 selects 100 or 10 Mbps; initial value from EEPROM.
// - Control bit 12 enables negotiation, overriding speed and duplex bits.
// - Writing control bit 9 restarts auto-negotiation.
// - Bit 8 duplex; with negotiation on reads negotiated duplex, writes store.
// - Status bits 15-11 and 0 are fixed ability constants.
// - Status bit 5 shows negotiation complete.
// - Status bit 4 latches remote fault; status read clears it.
// - Status bit 3 resets one, drops to zero after a link failure.
// - Status bit 2 shows present valid link.
// - Status bit 1 shows jabber presence.
// - Advert bits 15,14 read-only; bit 14 acknowledges partner word received.
// - Advert bit 13 writable remote fault advertisement, resets zero.
// - Advert bit 10 reads one, bit 9 reads zero.
// - Advert bits 8-5 writable abilities, reset one.
// - Advert selector bits 4-0 reset to 00001.
// - Partner register read-only, reset zero, captures received partner word.
// - Partner selector reads 00000 until a word is received.
// - Revision register returns the configuration space revision value.
// - Page received flag sets on new word, clears on partner register read.
module par_register_bank #(
    parameter int ADDR_W = 8,
    // Arbitrary revision value, also used by the configuration space
    parameter logic [7:0] REVISION_IDENTIFIER = 8'h01
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Register access
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Configuration load
    input wire logic eeprom_load_i,
    input wire logic eeprom_speed_100_i,
    input wire logic eeprom_autoneg_i,
    input wire logic eeprom_full_duplex_i,
    // Line side
    input wire logic link_ok_i,
    input wire logic jabber_i,
    input wire logic remote_fault_i,
    input wire logic partner_word_valid_i,
    input wire logic [15:0] partner_word_i,
    // Operating mode
    output logic line_speed_100_o,
    output logic full_duplex_o,
    output logic autoneg_complete_o,
    output logic [15:0] local_code_word_o,
    output logic page_received_o
);
    if (ADDR_W < 7 || ADDR_W > 16)
        $error("ADDR_W must lie between 7 and 16");

    par_nway_if nway ();

    logic speed_sel;
    logic autoneg_enable;
    logic restart_req;
    logic duplex_sel;
    logic ee_speed;
    logic ee_autoneg;
    logic ee_duplex;
    par_pkg::par_word_t advert_store;
    par_pkg::par_word_t partner_ability_word;
    logic remote_fault_flag;
    logic no_fail;
    logic wr_ctrl;
    logic wr_adv;
    logic rd_sts;
    logic rd_partner;
    logic soft_rst;
    par_pkg::par_word_t ctrl_view;
    par_pkg::par_word_t status_view;
    par_pkg::par_word_t advert_view;
    par_pkg::par_word_t next_rdata;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction

    assign wr_ctrl = reg_wr_i && hit(reg_addr_i, `PAR_OFS_CONTROL);
    assign wr_adv = reg_wr_i && hit(reg_addr_i, `PAR_OFS_ADVERT);
    assign rd_sts = reg_rd_i && hit(reg_addr_i, `PAR_OFS_STATUS);
    assign rd_partner = reg_rd_i && hit(reg_addr_i, `PAR_OFS_PARTNER);
    assign soft_rst = wr_ctrl && reg_wdata_i[`PAR_CTRL_RESET];

    // EEPROM values kept so that a software reset can restore them
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ee_speed <= 1'b0;
            ee_autoneg <= 1'b0;
            ee_duplex <= 1'b0;
        end
        else if (eeprom_load_i)
        begin
            ee_speed <= eeprom_speed_100_i;
            ee_autoneg <= eeprom_autoneg_i;
            ee_duplex <= eeprom_full_duplex_i;
        end
    end

    // Speed, enable and duplex selections
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            speed_sel <= 1'b0;
            autoneg_enable <= 1'b0;
            duplex_sel <= 1'b0;
        end
        else if (eeprom_load_i)
        begin
            speed_sel <= eeprom_speed_100_i;
            autoneg_enable <= eeprom_autoneg_i;
            duplex_sel <= eeprom_full_duplex_i;
        end
        else if (soft_rst)
        begin
            speed_sel <= ee_speed;
            autoneg_enable <= ee_autoneg;
            duplex_sel <= ee_duplex;
        end
        else if (wr_ctrl)
        begin
            speed_sel <= reg_wdata_i[`PAR_CTRL_SPEED];
            autoneg_enable <= reg_wdata_i[`PAR_CTRL_ANEN];
            duplex_sel <= reg_wdata_i[`PAR_CTRL_DUPLEX];
        end
    end

    // Restart request stands until the sequencer has taken it
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            restart_req <= 1'b0;
        else if (wr_ctrl && !soft_rst && reg_wdata_i[`PAR_CTRL_RESTART])
            restart_req <= 1'b1;
        else if (nway.restart_taken || soft_rst)
            restart_req <= 1'b0;
    end

    // Writable advertisement fields
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            advert_store <= `PAR_ADV_RESET;
        else if (soft_rst)
            advert_store <= `PAR_ADV_RESET;
        else if (wr_adv)
            advert_store <= reg_wdata_i & `PAR_ADV_WR_MASK;
    end

    // Partner word capture
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            partner_ability_word <= `PAR_PARTNER_RESET;
        else if (soft_rst)
            partner_ability_word <= `PAR_PARTNER_RESET;
        else if (nway.page_rx)
            partner_ability_word <= partner_word_i;
    end

    // Page received flag; a new word beats a clearing read
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            page_received_o <= 1'b0;
        else if (nway.page_rx)
            page_received_o <= 1'b1;
        else if (rd_partner || soft_rst)
            page_received_o <= 1'b0;
    end

    par_status_flags u_flags (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .soft_rst_i(soft_rst),
        .status_read_i(rd_sts),
        .remote_fault_i(remote_fault_i),
        .link_ok_i(link_ok_i),
        .remote_fault_o(remote_fault_flag),
        .no_fail_o(no_fail)
    );

    // Sequencer resolves the stored advertisement against the received word
    assign nway.enable = autoneg_enable;
    assign nway.restart = restart_req;
    assign nway.soft_rst = soft_rst;
    assign nway.advert = advert_store;
    assign nway.rx_word = partner_word_i;
    assign nway.partner_valid = partner_word_valid_i;
    assign nway.link_ok = link_ok_i;

    par_nway_sequencer u_seq (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .nw(nway.seq)
    );

    // Register views as software sees them
    always_comb
    begin
        ctrl_view = 16'h0000;
        ctrl_view[`PAR_CTRL_SPEED] = speed_sel;
        ctrl_view[`PAR_CTRL_ANEN] = autoneg_enable;
        ctrl_view[`PAR_CTRL_RESTART] = restart_req;
        ctrl_view[`PAR_CTRL_DUPLEX] = autoneg_enable ? full_duplex_o : duplex_sel;
    end

    always_comb
    begin
        status_view = `PAR_STS_FIXED;
        status_view[`PAR_STS_COMPLETE] = nway.complete;
        status_view[`PAR_STS_RFAULT] = remote_fault_flag;
        status_view[`PAR_STS_NOFAIL] = no_fail;
        status_view[`PAR_STS_LINK] = link_ok_i;
        status_view[`PAR_STS_JABBER] = jabber_i;
    end

    always_comb
    begin
        advert_view = advert_store;
        advert_view[`PAR_ADV_NP] = 1'b0;
        advert_view[`PAR_ADV_ACK] = nway.ack;
        advert_view[`PAR_ADV_PAUSE] = 1'b1;
        advert_view[`PAR_ADV_T4] = 1'b0;
    end

    // Unmapped offsets read zero
    always_comb
    begin
        next_rdata = 16'h0000;
        if (hit(reg_addr_i, `PAR_OFS_REVISION))
            next_rdata = {8'h00, REVISION_IDENTIFIER};
        else if (hit(reg_addr_i, `PAR_OFS_CONTROL))
            next_rdata = ctrl_view;
        else if (hit(reg_addr_i, `PAR_OFS_STATUS))
            next_rdata = status_view;
        else if (hit(reg_addr_i, `PAR_OFS_ADVERT))
            next_rdata = advert_view;
        else if (hit(reg_addr_i, `PAR_OFS_PARTNER))
            next_rdata = partner_ability_word;
    end

    // Read strobe answered one cycle later
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            reg_rvalid_o <= 1'b0;
        else
            reg_rvalid_o <= reg_rd_i;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            reg_rdata_o <= 16'h0000;
        else if (reg_rd_i)
            reg_rdata_o <= next_rdata;
    end

    // Operating mode: negotiated result when enabled, else forced bits
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            line_speed_100_o <= 1'b0;
            full_duplex_o <= 1'b0;
        end
        else
        begin
            line_speed_100_o <= autoneg_enable ? (nway.complete && nway.speed_100) : speed_sel;
            full_duplex_o <= autoneg_enable ? (nway.complete && nway.full_duplex) : duplex_sel;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            autoneg_complete_o <= 1'b0;
        else
            autoneg_complete_o <= nway.complete;
    end

    // Code word for the line; fixed pause bit already set in reset
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            local_code_word_o <= `PAR_ADV_VIEW_RESET;
        else
            local_code_word_o <= advert_view;
    end
endmodule

// file: par_register_bank_assertions.sv
// Port checks of the PHY register bank
`timescale 1ns/1ps
`include "par_consts.svh"
module par_register_bank_assertions #(
    parameter int ADDR_W = 8,
    parameter logic [7:0] REVISION_IDENTIFIER = 8'h01
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Register access
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    // Line side
    input wire logic link_ok_i,
    input wire logic jabber_i,
    input wire logic remote_fault_i,
    input wire logic partner_word_valid_i,
    // Mode outputs
    input wire logic [15:0] local_code_word_o,
    input wire logic page_received_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    logic rd_sts;
    assign rd_sts = reg_rd_i && reg_addr_i == `PAR_OFS_STATUS;
    fixed_ability_a: assert property (rd_sts |=> reg_rdata_o[15:11] == 5'h0f && reg_rdata_o[0])
        else $error("fixed status bits wrong");
    link_level_a: assert property (rd_sts |=> reg_rdata_o[2] == $past(link_ok_i))
        else $error("link bit does not follow the line");
    jabber_level_a: assert property (rd_sts |=> reg_rdata_o[1] == $past(jabber_i))
        else $error("jabber bit does not follow the line");
    fault_clear_a: assert property ((rd_sts && !remote_fault_i) ##1 !remote_fault_i
        ##1 (rd_sts && !remote_fault_i) |=> !reg_rdata_o[4])
        else $error("remote fault not cleared by read");
    advert_fixed_a: assert property (!local_code_word_o[15] && local_code_word_o[10:9] == 2'b10)
        else $error("fixed advert bits wrong");
    page_clear_a: assert property (reg_rd_i && reg_addr_i == `PAR_OFS_PARTNER
        && !partner_word_valid_i |=> !page_received_o)
        else $error("page flag not cleared by partner read");
    soft_reset_a: assert property (reg_wr_i && reg_addr_i == `PAR_OFS_CONTROL && reg_wdata_i[15]
        && !partner_word_valid_i |=> !page_received_o ##1
        local_code_word_o[13:0] == 14'(`PAR_ADV_VIEW_RESET))
        else $error("soft reset did not restore defaults");
    revision_a: assert property (reg_rd_i && reg_addr_i == `PAR_OFS_REVISION
        |=> reg_rdata_o == {8'h00, REVISION_IDENTIFIER})
        else $error("revision value wrong");
endmodule
bind par_register_bank par_register_bank_assertions #(.ADDR_W(ADDR_W), .REVISION_IDENTIFIER(REVISION_IDENTIFIER))
    chk_u (.ref_clk_i, .resetn_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
    .link_ok_i, .jabber_i, .remote_fault_i, .partner_word_valid_i, .local_code_word_o,
    .page_received_o);

// file: par_link_partner.sv
// Behavioural remote link partner sending one code word on request
`timescale 1ns/1ps
module par_link_partner (
    // Clock
    input wire logic ref_clk_i,
    // Bench commands
    input wire logic send_i,
    input wire logic link_up_i,
    input wire logic [15:0] word_i,
    // Line side
    output logic word_valid_o,
    output logic link_ok_o,
    output logic [15:0] word_o
);
    initial
    begin
        word_valid_o = 1'b0;
        link_ok_o = 1'b1;
        word_o = 16'h0000;
    end
    // Word lines carry a changing pattern outside a transfer
    always @(posedge ref_clk_i)
    begin
        word_valid_o <= send_i;
        word_o <= send_i ? word_i : ~word_o;
        link_ok_o <= link_up_i;
    end
endmodule

// file: phy_autoneg_register_bank_test.sv
// Self-checking bench of the PHY register bank
`timescale 1ns/1ps
`include "par_consts.svh"
module phy_autoneg_register_bank_test;
    localparam logic [7:0] REV = 8'h3c; // Arbitrary revision value
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic eeprom_load_i = 1'b0;
    logic eeprom_speed_100_i = 1'b0;
    logic eeprom_autoneg_i = 1'b0;
    logic eeprom_full_duplex_i = 1'b0;
    logic jabber_i = 1'b0;
    logic remote_fault_i = 1'b0;
    logic send = 1'b0;
    logic link_up = 1'b1;
    logic [15:0] reg_rdata_o, local_code_word_o, partner_word_i, pw, v;
    logic reg_rvalid_o, link_ok_i, partner_word_valid_i, line_speed_100_o, full_duplex_o;
    logic autoneg_complete_o, page_received_o;
    logic [31:0] lfsr = 32'ha44be7e6;
    int errors = 0;
    int compares = 0;

    always #25 ref_clk_i = ~ref_clk_i;

    par_register_bank #(.ADDR_W(8), .REVISION_IDENTIFIER(REV)) dut_u (.ref_clk_i, .resetn_i, .reg_addr_i,
        .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .eeprom_load_i,
        .eeprom_speed_100_i, .eeprom_autoneg_i, .eeprom_full_duplex_i, .link_ok_i, .jabber_i,
        .remote_fault_i, .partner_word_valid_i, .partner_word_i, .line_speed_100_o,
        .full_duplex_o, .autoneg_complete_o, .local_code_word_o, .page_received_o);

    par_link_partner partner_u (.ref_clk_i(ref_clk_i), .send_i(send), .link_up_i(link_up),
        .word_i(pw), .word_valid_o(partner_word_valid_i), .link_ok_o(link_ok_i),
        .word_o(partner_word_i));

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Highest common ability as {speed_100, full_duplex}
    function automatic logic [1:0] resolve(input logic [15:0] a, input logic [15:0] p);
        logic [15:0] c;
        c = a & p;
        if (c[8])
            return 2'b11;
        if (c[7])
            return 2'b10;
        if (c[6])
            return 2'b01;
        return 2'b00;
    endfunction

    task automatic test_done;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
        compares++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(negedge ref_clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge ref_clk_i);
        reg_wr_i = 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [15:0] e, input string m);
        @(negedge ref_clk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge ref_clk_i);
        reg_rd_i = 1'b0;
        chk({15'h0, reg_rvalid_o}, 16'h0001, "read answer");
        chk(reg_rdata_o, e, m);
    endtask

    initial
    begin
        #(50 * 3000);
        errors++;
        $display("BAD %0t timeout", $time);
        test_done();
    end

    initial
    begin
        repeat (10) @(negedge ref_clk_i);
        resetn_i = 1'b1;
        rchk(`PAR_OFS_REVISION, {8'h00, REV}, "revision");
        rchk(`PAR_OFS_CONTROL, 16'h0000, "control");
        rchk(`PAR_OFS_STATUS, 16'h780d, "status");
        rchk(`PAR_OFS_ADVERT, `PAR_ADV_VIEW_RESET, "advert");
        rchk(`PAR_OFS_PARTNER, 16'h0000, "partner");
        rchk(8'h70, 16'h0000, "unmapped");
        for (int i = 0; i < 6; i++)
        begin
            lfsr = next_rand(lfsr);
            v = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : lfsr[15:0];
            wreg(`PAR_OFS_ADVERT, v);
            rchk(`PAR_OFS_ADVERT, (v & `PAR_ADV_WR_MASK) | 16'h0400, "advert write");
        end
        wreg(`PAR_OFS_ADVERT, `PAR_ADV_RESET);
        eeprom_speed_100_i = 1'b1;
        eeprom_full_duplex_i = 1'b1;
        eeprom_load_i = 1'b1;
        @(negedge ref_clk_i);
        eeprom_load_i = 1'b0;
        rchk(`PAR_OFS_CONTROL, 16'h2100, "loaded control");
        for (int i = 0; i < 4; i++)
        begin
            v = {2'b00, i[1], 4'h0, i[0], 8'h00};
            wreg(`PAR_OFS_CONTROL, v);
            rchk(`PAR_OFS_CONTROL, v, "forced control");
            chk({14'h0, line_speed_100_o, full_duplex_o}, {14'h0, v[13], v[8]}, "forced");
        end
        jabber_i = 1'b1;
        rchk(`PAR_OFS_STATUS, 16'h780f, "jabber");
        jabber_i = 1'b0;
        remote_fault_i = 1'b1;
        @(negedge ref_clk_i);
        remote_fault_i = 1'b0;
        rchk(`PAR_OFS_STATUS, 16'h781d, "fault set");
        rchk(`PAR_OFS_STATUS, 16'h780d, "fault clear");
        link_up = 1'b0;
        repeat (3) @(negedge ref_clk_i);
        rchk(`PAR_OFS_STATUS, 16'h7801, "link down");
        link_up = 1'b1;
        repeat (3) @(negedge ref_clk_i);
        rchk(`PAR_OFS_STATUS, 16'h7805, "past failure");
        wreg(`PAR_OFS_CONTROL, 16'h1200);
        rchk(`PAR_OFS_CONTROL, 16'h1000, "restart clear");
        lfsr = next_rand(lfsr);
        pw = (lfsr[15:0] & 16'h7fe0) | 16'h0021;
        send = 1'b1;
        @(negedge ref_clk_i);
        send = 1'b0;
        for (int k = 0; k < 20 && autoneg_complete_o !== 1'b1; k++)
            @(negedge ref_clk_i);
        v = {14'h0, resolve(`PAR_ADV_RESET, pw)};
        chk({13'h0, autoneg_complete_o, line_speed_100_o, full_duplex_o}, v | 16'h4, "nway");
        chk({15'h0, page_received_o}, 16'h0001, "page set");
        chk(local_code_word_o, `PAR_ADV_VIEW_RESET | 16'h4000, "ack");
        rchk(`PAR_OFS_STATUS, 16'h7825, "complete");
        rchk(`PAR_OFS_CONTROL, 16'h1000 | {7'h0, v[0], 8'h00}, "duplex status");
        rchk(`PAR_OFS_PARTNER, pw, "partner word");
        chk({15'h0, page_received_o}, 16'h0000, "page clear");
        wreg(`PAR_OFS_CONTROL, 16'hb3ff);
        rchk(`PAR_OFS_CONTROL, 16'h2100, "soft control");
        rchk(`PAR_OFS_STATUS, 16'h780d, "soft status");
        rchk(`PAR_OFS_ADVERT, `PAR_ADV_VIEW_RESET, "soft advert");
        rchk(`PAR_OFS_PARTNER, 16'h0000, "soft partner");
        eeprom_autoneg_i = 1'b1;
        eeprom_speed_100_i = 1'b0;
        eeprom_load_i = 1'b1;
        @(negedge ref_clk_i);
        eeprom_load_i = 1'b0;
        wreg(`PAR_OFS_CONTROL, 16'h8000);
        rchk(`PAR_OFS_CONTROL, 16'h1000, "soft autoneg");
        test_done();
    end
endmodule
